// ==== hdl/aic_pkg.sv ====
/*
 * aic_pkg: constants for the accumulator/parameter, error-flag and interrupt
 * command executor. Assumes frames arrive already byte-aligned from a link
 * receiver that lives outside this block.
 */
package aic_pkg;
    // frame layout: byte index within a 9-byte frame
    localparam int unsigned FRAME_BYTES   = 9;
    localparam int unsigned IDX_TARGET    = 0;
    localparam int unsigned IDX_INSTR     = 1;
    localparam int unsigned IDX_TYPE      = 2;
    localparam int unsigned IDX_BANK      = 3;
    localparam int unsigned IDX_VAL3      = 4;
    localparam int unsigned IDX_CSUM      = 8;

    // instruction codes
    localparam logic [7:0] OP_ACCU_TO_AXIS_PARAM   = 8'h22;  // 34
    localparam logic [7:0] OP_ACCU_TO_GLOBAL_PARAM = 8'h23;  // 35
    localparam logic [7:0] OP_CLEAR_ERROR_FLAGS    = 8'h24;  // 36
    localparam logic [7:0] OP_IRQ_ENABLE_CMD       = 8'h19;  // 25
    localparam logic [7:0] OP_IRQ_DISABLE_CMD      = 8'h1a;  // 26
    localparam logic [7:0] OP_IRQ_VECTOR_DEFINE    = 8'h25;  // 37
    localparam logic [7:0] OP_IRQ_RETURN           = 8'h26;  // 38

    // reply status codes
    localparam logic [7:0] STATUS_OK         = 8'h64;
    localparam logic [7:0] STATUS_BAD_CSUM   = 8'h01;
    localparam logic [7:0] STATUS_BAD_INSTR  = 8'h02;

    // special interrupt number meaning global processing enable
    localparam logic [7:0] IRQ_GLOBAL_NUM    = 8'hff;

    // error-flag clear selectors and flag bit positions
    localparam logic [7:0] CLR_ALL           = 8'h00;
    localparam logic [7:0] CLR_MAX           = 8'h05;
    localparam int unsigned FLAG_TIMEOUT     = 0;
    localparam int unsigned FLAG_EXT_ALARM   = 1;
    localparam int unsigned FLAG_DEVIATION   = 2;
    localparam int unsigned FLAG_POS_ERROR   = 3;
    localparam int unsigned FLAG_SHUTDOWN    = 4;
    localparam int unsigned NUM_FLAGS        = 5;

    // reset values
    localparam logic [7:0] HOST_ADDR_RST     = 8'h02;
    localparam logic [7:0] MODULE_ADDR_RST   = 8'h01;

    typedef enum logic [1:0] {
        AIC_IDLE,
        AIC_RX,
        AIC_EXEC,
        AIC_TX
    } aic_state_t;
endpackage : aic_pkg

// ==== hdl/aic_cmd_exec.sv ====
/*
 * aic_cmd_exec: executes accumulator-to-parameter, clear-error-flag and
 * interrupt enable/disable/vector/return instructions, and dispatches
 * interrupts to their vectors. Assumes command bytes come from a receiver
 * on the same clock (one byte per valid), and that standalone program
 * instructions arrive whole from the program sequencer on the same clock.
 */
// Notes on behaviour
// R01 - code 34 writes accumulator to axis parameter type, motor bank
// R02 - code 35 writes accumulator to global parameter type, bank
// R03 - issuer loads the accumulator before copying it to parameters
// R04 - code 36 clears error flags chosen by type; other fields ignored
// R05 - type 0 all, 1 timeout, 2 alarm, 3 deviation, 4 position, 5 shutdown
// R06 - code 25 enables the interrupt source named in type
// R07 - enable with number 255 sets the global interrupt enable
// R08 - code 26 disables the interrupt source named in type
// R09 - disable with number 255 clears the global interrupt enable
// R10 - enable and disable ignore bank byte and value bytes
// R11 - vector definition stores label as handler entry for that interrupt
// R12 - a vector may be redefined; newest definition wins
// R13 - issuer uses vector definition only inside a stored program
// R14 - code 37 is vector definition: number in type, label in value
// R15 - code 38 restores saved accumulator, index, flags and program counter
// R16 - reply: host, target, status, instruction, four value bytes, checksum
// R17 - checksum is modulo-256 sum of preceding bytes; bad frames rejected
// R18 - dispatch only when source and global enable set; save context first
`timescale 1ns/100ps
`default_nettype none

module aic_cmd_exec
    import aic_pkg::*;
#(
    parameter int unsigned NUM_IRQ  = 16,
    parameter int unsigned PC_W     = 16
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    // direct-mode command bytes from the link receiver
    input  wire logic              rx_valid_in,
    input  wire logic [7:0]        rx_byte_in,
    // reply bytes to the link transmitter
    output logic                   tx_valid_out,
    output logic [7:0]             tx_byte_out,
    input  wire logic              tx_ready_in,
    // standalone program instruction
    input  wire logic              prog_valid_in,
    input  wire logic [7:0]        prog_instr_in,
    input  wire logic [7:0]        prog_type_in,
    input  wire logic [7:0]        prog_bank_in,
    input  wire logic [31:0]       prog_value_in,
    // program core context
    input  wire logic [31:0]       accu_in,
    input  wire logic [31:0]       index_in,
    input  wire logic [7:0]        cpu_flags_in,
    input  wire logic [PC_W-1:0]   pc_in,
    output logic                   restore_out,
    output logic [31:0]            accu_restore_out,
    output logic [31:0]            index_restore_out,
    output logic [7:0]             flags_restore_out,
    output logic [PC_W-1:0]        pc_restore_out,
    output logic                   irq_jump_out,
    output logic [PC_W-1:0]        irq_target_out,
    // parameter write port
    output logic                   axis_wr_out,
    output logic                   global_wr_out,
    output logic [7:0]             param_num_out,
    output logic [7:0]             param_bank_out,
    output logic [31:0]            param_data_out,
    // error flags and interrupt sources
    input  wire logic [NUM_FLAGS-1:0] err_set_in,
    output logic [NUM_FLAGS-1:0]   err_flags_out,
    input  wire logic [NUM_IRQ-1:0] irq_req_in,
    output logic [NUM_IRQ-1:0]     irq_enable_out,
    output logic                   irq_global_out,
    output logic                   in_handler_out
);

    // ==========
    // frame receive
    // ==========
    aic_state_t  state_reg;
    logic [7:0]  frame_reg [FRAME_BYTES];
    logic [3:0]  rx_cnt_reg;
    logic [7:0]  sum_reg;
    logic [3:0]  tx_cnt_reg;
    logic [7:0]  tx_sum_reg;
    logic [7:0]  status_reg;

    wire  logic  frame_last  = rx_valid_in && (rx_cnt_reg == 4'(FRAME_BYTES - 1));
    wire  logic  csum_ok     = (sum_reg == rx_byte_in);                     // [R17]

    // ==========
    // instruction source select: program has priority over link
    // ==========
    wire  logic        host_go   = (state_reg == AIC_EXEC);
    wire  logic        exec_go   = prog_valid_in || (host_go && status_reg == STATUS_OK);
    wire  logic [7:0]  ex_instr  = prog_valid_in ? prog_instr_in : frame_reg[IDX_INSTR];
    wire  logic [7:0]  ex_type   = prog_valid_in ? prog_type_in  : frame_reg[IDX_TYPE];
    wire  logic [7:0]  ex_bank   = prog_valid_in ? prog_bank_in  : frame_reg[IDX_BANK];
    wire  logic [31:0] ex_value  = prog_valid_in ? prog_value_in :
        {frame_reg[IDX_VAL3], frame_reg[IDX_VAL3+1], frame_reg[IDX_VAL3+2], frame_reg[IDX_VAL3+3]};

    wire  logic is_aap  = exec_go && ex_instr == OP_ACCU_TO_AXIS_PARAM;     // [R01]
    wire  logic is_agp  = exec_go && ex_instr == OP_ACCU_TO_GLOBAL_PARAM;   // [R02]
    wire  logic is_clr  = exec_go && ex_instr == OP_CLEAR_ERROR_FLAGS;      // [R04]
    wire  logic is_en   = exec_go && ex_instr == OP_IRQ_ENABLE_CMD;         // [R06]
    wire  logic is_dis  = exec_go && ex_instr == OP_IRQ_DISABLE_CMD;        // [R08]
    wire  logic is_vec  = exec_go && ex_instr == OP_IRQ_VECTOR_DEFINE;      // [R14]
    wire  logic is_ret  = exec_go && ex_instr == OP_IRQ_RETURN && in_handler_out;
    wire  logic known   = frame_reg[IDX_INSTR] inside {OP_ACCU_TO_AXIS_PARAM, OP_ACCU_TO_GLOBAL_PARAM,
        OP_CLEAR_ERROR_FLAGS, OP_IRQ_ENABLE_CMD, OP_IRQ_DISABLE_CMD, OP_IRQ_VECTOR_DEFINE, OP_IRQ_RETURN};
    wire  logic is_glob = ex_type == IRQ_GLOBAL_NUM;                        // [R07] [R09]

    // type 0 selects all, 1..5 one flag; out-of-range selectors clear nothing
    logic [NUM_FLAGS-1:0] clr_mask;
    always_comb begin                                                       // [R05]
        clr_mask = '0;
        if (ex_type == CLR_ALL) begin
            clr_mask = '1;
        end else if (ex_type <= CLR_MAX) begin
            clr_mask[ex_type[2:0] - 3'h1] = 1'b1;
        end
    end

    // ==========
    // interrupt enables, vectors, dispatch
    // ==========
    logic [PC_W-1:0]     vector_reg [NUM_IRQ];
    logic [NUM_IRQ-1:0]  pending;
    logic [$clog2(NUM_IRQ)-1:0] pick;
    assign pending = irq_req_in & irq_enable_out;
    always_comb begin
        pick = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (pending[i]) begin
                pick = ($clog2(NUM_IRQ))'(i);
            end
        end
    end
    // no nesting; never dispatch while a program instruction is in flight
    wire logic dispatch = irq_global_out && |pending && !in_handler_out && !prog_valid_in; // [R18]

    logic [31:0]     sv_accu_reg;
    logic [31:0]     sv_index_reg;
    logic [7:0]      sv_flags_reg;
    logic [PC_W-1:0] sv_pc_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_IRQ; g++) begin : g_irq
            wire logic hit = ex_type == 8'(g);
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    irq_enable_out[g] <= 1'b0;
                    vector_reg[g]     <= '0;
                end else begin
                    if (is_en && hit) begin
                        irq_enable_out[g] <= 1'b1;                          // [R06]
                    end else if (is_dis && hit) begin
                        irq_enable_out[g] <= 1'b0;                          // [R08] [R10]
                    end
                    if (is_vec && hit) begin
                        vector_reg[g] <= ex_value[PC_W-1:0];                // [R11] [R12]
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_global_out <= 1'b0;
            in_handler_out <= 1'b0;
            irq_jump_out   <= 1'b0;
            irq_target_out <= '0;
            restore_out    <= 1'b0;
            sv_accu_reg    <= '0;
            sv_index_reg   <= '0;
            sv_flags_reg   <= '0;
            sv_pc_reg      <= '0;
        end else begin
            irq_jump_out <= dispatch;
            restore_out  <= is_ret;                                         // [R15]
            if (is_en && is_glob) begin
                irq_global_out <= 1'b1;                                     // [R07]
            end else if (is_dis && is_glob) begin
                irq_global_out <= 1'b0;                                     // [R09]
            end
            if (dispatch) begin
                sv_accu_reg    <= accu_in;                                  // [R18]
                sv_index_reg   <= index_in;
                sv_flags_reg   <= cpu_flags_in;
                sv_pc_reg      <= pc_in;
                irq_target_out <= vector_reg[pick];
                in_handler_out <= 1'b1;
            end else if (is_ret) begin
                in_handler_out <= 1'b0;
            end
        end
    end
    assign accu_restore_out  = sv_accu_reg;
    assign index_restore_out = sv_index_reg;
    assign flags_restore_out = sv_flags_reg;
    assign pc_restore_out    = sv_pc_reg;

    // ==========
    // parameter write and error flags
    // ==========
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            axis_wr_out    <= 1'b0;
            global_wr_out  <= 1'b0;
            param_num_out  <= '0;
            param_bank_out <= '0;
            param_data_out <= '0;
            err_flags_out  <= '0;
        end else begin
            axis_wr_out    <= is_aap;                                       // [R01]
            global_wr_out  <= is_agp;                                       // [R02]
            param_num_out  <= ex_type;
            param_bank_out <= ex_bank;
            param_data_out <= accu_in;                                      // [R03]
            // a new error in the same cycle as its clear survives
            err_flags_out  <= (err_flags_out & ~(is_clr ? clr_mask : '0)) | err_set_in; // [R04]
        end
    end

    // ==========
    // frame sequencer and reply
    // ==========
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg    <= AIC_IDLE;
            rx_cnt_reg   <= '0;
            sum_reg      <= '0;
            status_reg   <= STATUS_OK;
            tx_cnt_reg   <= '0;
            tx_sum_reg   <= '0;
            tx_valid_out <= 1'b0;
            tx_byte_out  <= '0;
            for (int i = 0; i < FRAME_BYTES; i++) begin
                frame_reg[i] <= '0;
            end
        end else begin
            case (state_reg)
                AIC_IDLE, AIC_RX: begin
                    if (rx_valid_in) begin
                        frame_reg[rx_cnt_reg] <= rx_byte_in;
                        sum_reg    <= sum_reg + rx_byte_in;                 // [R17]
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        state_reg  <= AIC_RX;
                        if (frame_last) begin
                            rx_cnt_reg <= '0;
                            sum_reg    <= '0;
                            state_reg  <= AIC_EXEC;
                            status_reg <= !csum_ok ? STATUS_BAD_CSUM :      // [R17]
                                          !known   ? STATUS_BAD_INSTR : STATUS_OK;
                        end
                    end
                end
                AIC_EXEC: begin
                    // a program instruction this cycle holds the host one back
                    if (!prog_valid_in) begin
                        state_reg  <= AIC_TX;
                        tx_cnt_reg <= '0;
                        tx_sum_reg <= '0;
                    end
                end
                AIC_TX: begin
                    if (!tx_valid_out || tx_ready_in) begin
                        if (tx_cnt_reg == 4'(FRAME_BYTES)) begin
                            tx_valid_out <= 1'b0;
                            state_reg    <= AIC_IDLE;
                        end else begin
                            tx_valid_out <= 1'b1;
                            tx_cnt_reg   <= tx_cnt_reg + 4'h1;
                            case (tx_cnt_reg)                               // [R16]
                                4'h0:    tx_byte_out <= HOST_ADDR_RST;
                                4'h1:    tx_byte_out <= MODULE_ADDR_RST;
                                4'h2:    tx_byte_out <= status_reg;
                                4'h3:    tx_byte_out <= frame_reg[IDX_INSTR];
                                4'h8:    tx_byte_out <= tx_sum_reg;         // [R17]
                                default: tx_byte_out <= 8'h00;
                            endcase
                            if (tx_cnt_reg != 4'h8) begin
                                tx_sum_reg <= tx_sum_reg + (tx_cnt_reg == 4'h0 ? HOST_ADDR_RST :
                                    tx_cnt_reg == 4'h1 ? MODULE_ADDR_RST :
                                    tx_cnt_reg == 4'h2 ? status_reg :
                                    tx_cnt_reg == 4'h3 ? frame_reg[IDX_INSTR] : 8'h00);
                            end
                        end
                    end
                end
                default: state_reg <= AIC_IDLE;
            endcase
        end
    end

endmodule // aic_cmd_exec

`default_nettype wire

// ==== tb/aic_cmd_exec_assertions.sv ====
/*
 * aic_cmd_exec_checker: port-level assertions for aic_cmd_exec.
 * Assumes it is bound to the design top and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module aic_cmd_exec_checker
    import aic_pkg::*;
#(
    parameter int unsigned NUM_IRQ = 16,
    parameter int unsigned PC_W    = 16
) (
    // clock, reset and program port
    input wire logic                 clk_in, srst_in, prog_valid_in,
    input wire logic [7:0]           prog_instr_in, prog_type_in, prog_bank_in,
    input wire logic [31:0]          accu_in,
    // parameter writes and context
    input wire logic                 axis_wr_out, global_wr_out, irq_jump_out, restore_out,
    input wire logic [7:0]           param_num_out, param_bank_out,
    input wire logic [31:0]          param_data_out,
    // flags, interrupts and reply handshake
    input wire logic [NUM_FLAGS-1:0] err_set_in, err_flags_out,
    input wire logic [NUM_IRQ-1:0]   irq_req_in, irq_enable_out,
    input wire logic                 irq_global_out, in_handler_out, tx_valid_out, tx_ready_in,
    input wire logic [7:0]           tx_byte_out
);
    // ==========
    // command decode
    wire logic [7:0] p_op = prog_valid_in ? prog_instr_in : 8'h00;
    wire logic p_aap = p_op == OP_ACCU_TO_AXIS_PARAM;
    wire logic p_agp = p_op == OP_ACCU_TO_GLOBAL_PARAM;
    wire logic p_clr = p_op == OP_CLEAR_ERROR_FLAGS;
    wire logic p_ei  = p_op == OP_IRQ_ENABLE_CMD;
    wire logic p_di  = p_op == OP_IRQ_DISABLE_CMD;
    wire logic p_ret = p_op == OP_IRQ_RETURN;
    wire logic low_n = prog_type_in < NUM_IRQ;

    // ==========
    // properties
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    a_axis_copy: assert property (p_aap |=> axis_wr_out && param_data_out == $past(accu_in)
        && param_num_out == $past(prog_type_in) && param_bank_out == $past(prog_bank_in))
        else $error("axis parameter copy wrong");
    a_global_copy: assert property (p_agp |=> global_wr_out && param_data_out == $past(accu_in)
        && param_num_out == $past(prog_type_in) && param_bank_out == $past(prog_bank_in))
        else $error("global parameter copy wrong");
    a_clear_all: assert property (p_clr && prog_type_in == CLR_ALL
        |=> (err_flags_out & ~$past(err_set_in)) == 5'h00) else $error("clear all left a flag");
    a_clear_one: assert property (p_clr && prog_type_in != CLR_ALL && prog_type_in <= CLR_MAX
        |=> (((err_flags_out & ~$past(err_set_in)) >> ($past(prog_type_in) - 8'h01)) & 5'h01) == 5'h00)
        else $error("selected flag not cleared");
    a_enable_one: assert property (p_ei && low_n |=> irq_enable_out[$past(prog_type_in)])
        else $error("source not enabled");
    a_disable_one: assert property (p_di && low_n |=> !irq_enable_out[$past(prog_type_in)])
        else $error("source not disabled");
    a_global_on: assert property (p_ei && prog_type_in == IRQ_GLOBAL_NUM
        |=> irq_global_out && $stable(irq_enable_out)) else $error("global enable not set");
    a_global_off: assert property (p_di && prog_type_in == IRQ_GLOBAL_NUM
        |=> !irq_global_out && $stable(irq_enable_out)) else $error("global enable not cleared");
    a_dispatch_gate: assert property (irq_jump_out |-> in_handler_out && $past(irq_global_out)
        && $past(|(irq_req_in & irq_enable_out)) && !$past(in_handler_out) && !$past(prog_valid_in))
        else $error("bad dispatch");
    a_return_restore: assert property (p_ret && in_handler_out |=> restore_out && !in_handler_out)
        else $error("return did not restore");
    a_reply_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
        else $error("reply byte dropped while stalled");
endmodule // aic_cmd_exec_checker
`default_nettype wire

// ==== tb/aic_host_model.sv ====
/*
 * aic_host_model: host sending framed commands and collecting replies.
 * Assumes the bench calls exchange() and reads reply[] afterwards.
 */
`timescale 1ns/100ps
`default_nettype none
module aic_host_model (
    input  wire logic       clk_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_byte_in,
    output logic            rx_valid_out,
    output logic [7:0]      rx_byte_out,
    output logic            tx_ready_out
);
    logic [7:0] reply [9];
    initial begin
        rx_valid_out = 1'b0;
        rx_byte_out  = 8'h00;
        tx_ready_out = 1'b0;
    end
    // ==========
    // one frame out, one reply in; slow stalls every other cycle
    task automatic exchange(input logic [7:0] ins, ty, bk, input logic [31:0] val, input logic bad, slow);
        logic [7:0] f [9];
        int         n;
        f = '{8'h01, ins, ty, bk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (int i = 0; i < 8; i++) f[8] = f[8] + f[i];
        if (bad) f[8] = f[8] + 8'h01;
        reply = '{default: 8'hxx};
        for (int i = 0; i < 9; i++) begin
            @(negedge clk_in);
            rx_valid_out = 1'b1;
            rx_byte_out  = f[i];
        end
        @(negedge clk_in);
        rx_valid_out = 1'b0;
        // released line must not keep showing the last byte
        rx_byte_out  = ~f[8];
        n = 0;
        for (int c = 0; c < 60 && n < 9; c++) begin
            @(negedge clk_in);
            tx_ready_out = slow ? ~tx_ready_out : 1'b1;
            // byte and valid are settled here; the next rising edge takes them
            if (tx_valid_in === 1'b1 && tx_ready_out) begin
                reply[n] = tx_byte_in;
                n++;
            end
        end
        @(negedge clk_in);
        tx_ready_out = 1'b0;
    endtask
endmodule // aic_host_model
`default_nettype wire

// ==== tb/aic_cmd_exec_bench.sv ====
/*
 * aic_cmd_exec_bench: directed self-checking bench for aic_cmd_exec.
 * Assumes default parameters; inputs change on the falling edge.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module aic_cmd_exec_bench;
    import aic_pkg::*;
    logic clk_in = 1'b0, srst_in = 1'b1, prog_valid_in = 1'b0, tx_valid_out, tx_ready_in, rx_valid_in;
    logic [7:0] prog_instr_in = 8'h00, prog_type_in = 8'h00, prog_bank_in = 8'h00, rx_byte_in, tx_byte_out;
    logic [31:0] prog_value_in = 32'h0, accu_in = 32'h0, index_in = 32'h0, accu_r, index_r, param_data_out;
    logic [7:0] cpu_flags_in = 8'h00, flags_r, param_num_out, param_bank_out;
    logic [15:0] pc_in = 16'h0, pc_r, irq_target_out, irq_req_in = 16'h0, irq_enable_out;
    logic [4:0] err_set_in = 5'h00, err_flags_out, exp;
    logic restore_out, irq_jump_out, axis_wr_out, global_wr_out, irq_global_out, in_handler_out;
    int bad_count = 0, num_checks = 0, gwr_count = 0, base;
    always #5 clk_in = ~clk_in;
    always @(negedge clk_in) if (global_wr_out === 1'b1) gwr_count++;

    aic_cmd_exec dut (.clk_in(clk_in), .srst_in(srst_in), .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in),
        .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out), .tx_ready_in(tx_ready_in),
        .prog_valid_in(prog_valid_in), .prog_instr_in(prog_instr_in), .prog_type_in(prog_type_in),
        .prog_bank_in(prog_bank_in), .prog_value_in(prog_value_in), .accu_in(accu_in), .index_in(index_in),
        .cpu_flags_in(cpu_flags_in), .pc_in(pc_in), .restore_out(restore_out), .accu_restore_out(accu_r),
        .index_restore_out(index_r), .flags_restore_out(flags_r), .pc_restore_out(pc_r),
        .irq_jump_out(irq_jump_out), .irq_target_out(irq_target_out), .axis_wr_out(axis_wr_out),
        .global_wr_out(global_wr_out), .param_num_out(param_num_out), .param_bank_out(param_bank_out),
        .param_data_out(param_data_out), .err_set_in(err_set_in), .err_flags_out(err_flags_out),
        .irq_req_in(irq_req_in), .irq_enable_out(irq_enable_out), .irq_global_out(irq_global_out),
        .in_handler_out(in_handler_out));
    aic_host_model host (.clk_in(clk_in), .tx_valid_in(tx_valid_out), .tx_byte_in(tx_byte_out),
        .rx_valid_out(rx_valid_in), .rx_byte_out(rx_byte_in), .tx_ready_out(tx_ready_in));

    // ==========
    // program-port request: one cycle, effects seen on return
    task automatic prog(input logic [7:0] ins, ty, bk, input logic [31:0] val);
        @(negedge clk_in);
        {prog_valid_in, prog_instr_in, prog_type_in, prog_bank_in, prog_value_in} = {1'b1, ins, ty, bk, val};
        @(negedge clk_in);
        prog_valid_in = 1'b0;
    endtask
    task automatic t_accu_params();
        accu_in = 32'ha5a5_0001;
        prog(OP_ACCU_TO_AXIS_PARAM, 8'h05, 8'h01, 32'h0);
        `CHK({axis_wr_out, global_wr_out, param_num_out, param_bank_out, param_data_out}, {2'b10, 16'h0501, accu_in})
        accu_in = 32'h1234_5678;
        prog(OP_ACCU_TO_GLOBAL_PARAM, 8'h2a, 8'h02, 32'h0);
        `CHK({axis_wr_out, global_wr_out, param_num_out, param_bank_out, param_data_out}, {2'b01, 16'h2a02, accu_in})
    endtask
    task automatic t_clear_flags();
        for (int t = 0; t <= 6; t++) begin
            @(negedge clk_in) err_set_in = 5'h1f;
            @(negedge clk_in) err_set_in = 5'h00;
            prog(OP_CLEAR_ERROR_FLAGS, t[7:0], 8'h7e, 32'hffff_ffff);
            exp = (t == 0) ? 5'h00 : (t > 5) ? 5'h1f : 5'h1f & ~(5'h01 << (t - 1));
            `CHK(err_flags_out, exp)
        end
    endtask
    task automatic t_irq_enables();
        prog(OP_IRQ_ENABLE_CMD, 8'h03, 8'h55, 32'hdead_beef);
        `CHK({irq_global_out, irq_enable_out}, {1'b0, 16'h0008})
        prog(OP_IRQ_ENABLE_CMD, 8'hff, 8'h55, 32'hdead_beef);
        `CHK({irq_global_out, irq_enable_out}, {1'b1, 16'h0008})
        prog(OP_IRQ_DISABLE_CMD, 8'h03, 8'haa, 32'h1234_0000);
        `CHK({irq_global_out, irq_enable_out}, {1'b1, 16'h0000})
        prog(OP_IRQ_DISABLE_CMD, 8'hff, 8'haa, 32'h1234_0000);
        `CHK({irq_global_out, irq_enable_out}, {1'b0, 16'h0000})
    endtask
    task automatic t_vector_dispatch();
        prog(OP_IRQ_VECTOR_DEFINE, 8'h03, 8'h00, 32'h0000_0050);
        prog(OP_IRQ_VECTOR_DEFINE, 8'h03, 8'h00, 32'h0000_0123);
        prog(OP_IRQ_ENABLE_CMD, 8'h03, 8'h00, 32'h0);
        {accu_in, index_in, cpu_flags_in, pc_in, irq_req_in} = {32'hcafe_0001, 32'h777, 8'h5a, 16'h0042, 16'h0008};
        repeat (3) @(negedge clk_in);
        `CHK({irq_jump_out, in_handler_out}, 2'b00)
        prog(OP_IRQ_ENABLE_CMD, 8'hff, 8'h00, 32'h0);
        for (int n = 0; n < 10 && irq_jump_out !== 1'b1; n++) @(negedge clk_in);
        `CHK({irq_jump_out, in_handler_out, irq_target_out}, {2'b11, 16'h0123})
        {accu_in, index_in, cpu_flags_in, pc_in, irq_req_in} = {64'h0, 8'h00, 16'h0099, 16'h0000};
        prog(OP_IRQ_RETURN, 8'hff, 8'h00, 32'h0);
        `CHK({restore_out, in_handler_out, accu_r, index_r, flags_r, pc_r}, {2'b10, 32'hcafe_0001, 32'h777, 24'h5a_0042})
        prog(OP_IRQ_DISABLE_CMD, 8'hff, 8'h00, 32'h0);
    endtask
    task automatic t_link();
        logic [7:0] e [9];
        e = '{8'h02, 8'h01, STATUS_OK, OP_ACCU_TO_GLOBAL_PARAM, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) e[8] = e[8] + e[i];
        base = gwr_count;
        host.exchange(OP_ACCU_TO_GLOBAL_PARAM, 8'h2a, 8'h02, 32'h0, 1'b0, 1'b1);
        `CHK(gwr_count, base + 1)
        for (int i = 0; i < 9; i++) `CHK(host.reply[i], e[i])
        // corrupted checksum: answered, but nothing written
        host.exchange(OP_ACCU_TO_GLOBAL_PARAM, 8'h2a, 8'h02, 32'h0, 1'b1, 1'b0);
        `CHK({gwr_count, host.reply[2]}, {base + 1, STATUS_BAD_CSUM})
        host.exchange(8'h30, 8'h00, 8'h00, 32'h0, 1'b0, 1'b0);
        `CHK(host.reply[2], STATUS_BAD_INSTR)
    endtask

    // ==========
    // verdict and run control
    task automatic summarize();
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (6) @(negedge clk_in);
        srst_in = 1'b0;
        t_accu_params();
        t_clear_flags();
        t_irq_enables();
        t_vector_dispatch();
        t_link();
        summarize();
    end
endmodule // aic_cmd_exec_bench
bind aic_cmd_exec aic_cmd_exec_checker #(.NUM_IRQ(NUM_IRQ), .PC_W(PC_W)) u_chk (.clk_in(clk_in), .srst_in(srst_in),
    .prog_valid_in(prog_valid_in), .prog_instr_in(prog_instr_in), .prog_type_in(prog_type_in),
    .prog_bank_in(prog_bank_in), .accu_in(accu_in), .axis_wr_out(axis_wr_out), .global_wr_out(global_wr_out),
    .irq_jump_out(irq_jump_out), .restore_out(restore_out), .param_num_out(param_num_out),
    .param_bank_out(param_bank_out), .param_data_out(param_data_out), .err_set_in(err_set_in),
    .err_flags_out(err_flags_out), .irq_req_in(irq_req_in), .irq_enable_out(irq_enable_out),
    .irq_global_out(irq_global_out), .in_handler_out(in_handler_out), .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready_in), .tx_byte_out(tx_byte_out));
`default_nettype wire
